// ### pmic_dev.sv
/*
  Device end: control pins, reset generator and serial register slave
  of the power-management block.
  Assumes every pin input is asynchronous and the bus clock is at most
  a tenth of the system clock.
*/
`timescale 1ns/100ps
// Contract
// R1: buck3 default 1.8 V low, 3.3 V high
// R2: buck2 default 1.8 V low, 3.3 V high
// R3: core default 1.2 V low, 1.6 V high
// R4: each buck follows its own enable pin
// R5: warm reset restores only core target
// R6: warm reset input is debounced first
// R7: debounce filter time 30 ms
// R8: reset low at power-up, rail low, delay
// R9: hold delay 100 ms per nF
// R10: warm reset also pulses system reset
// R11: standard and fast mode, up to 400 kHz
// R12: registers kept while supply present
// R13: answer only to address 1001000
// R14: unmapped register reads return FFh
// R15: data changes only while clock low
// R16: master frames transfers with start, stop
// R17: slave acks each byte, low through high
// R18: master gives ninth clock for ack
// R19: master nack ends read, slave releases
// R20: read-only revision register at 00h
// R21: write ptr then data; read after restart
module pmic_dev #(
  parameter int unsigned HOLD_CYC = pmic_pkg::HOLD_CYC,
  parameter int unsigned DEB_CYC = pmic_pkg::DEB_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic buck3_default_select_i,
  input wire logic buck2_default_select_i,
  input wire logic core_buck_default_select_i,
  input wire logic buck3_enable_in_i,
  input wire logic buck2_enable_in_i,
  input wire logic core_buck_enable_in_i,
  input wire logic warm_reset_in_n_i,
  input wire logic backup_rail_ok_i,
  pmic_i2c_if.dev bus,
  output logic [7:0] core_buck_output_code_o,
  output logic [7:0] buck2_output_code_o,
  output logic [7:0] buck3_output_code_o,
  output logic core_buck_en_o,
  output logic buck2_en_o,
  output logic buck3_en_o,
  output logic system_reset_out_o,
  output logic system_reset_out_oe_o
);
  localparam int unsigned HW = $clog2(HOLD_CYC + 1);
  localparam int unsigned DW = $clog2(DEB_CYC + 1);

  logic [9:0] pins_s;
  logic def3_s, def2_s, def1_s, en3_s, en2_s, en1_s;
  logic warm_n_s, rail_s, scl_s, sda_s;
  logic scl_p_q, sda_p_q;
  logic warm_deb_q;
  logic [DW-1:0] deb_cnt_q;
  logic rst_hold_q;
  logic [HW-1:0] hold_cnt_q;
  logic [7:0] core_q;
  pmic_pkg::pmic_sst_t st_q, nxt_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] ptr_q;
  logic sda_oe_q;

  // All pins cross into the system clock domain first
  pmic_sync #(.W(10)) u_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .d_i({buck3_default_select_i, buck2_default_select_i,
          core_buck_default_select_i, buck3_enable_in_i, buck2_enable_in_i,
          core_buck_enable_in_i, warm_reset_in_n_i, backup_rail_ok_i,
          bus.scl, bus.sda}),
    .q_o(pins_s)
  );
  assign {def3_s, def2_s, def1_s, en3_s, en2_s, en1_s} = pins_s[9:4];
  assign {warm_n_s, rail_s, scl_s, sda_s} = pins_s[3:0];

  // Default targets decoded from the select pins
  logic [7:0] buck3_dflt, buck2_dflt, core_dflt;
  assign buck3_dflt = def3_s ? pmic_pkg::CODE_3V3 : pmic_pkg::CODE_1V8; // [R1]
  assign buck2_dflt = def2_s ? pmic_pkg::CODE_3V3 : pmic_pkg::CODE_1V8; // [R2]
  assign core_dflt = def1_s ? pmic_pkg::CODE_1V6 : pmic_pkg::CODE_1V2; // [R3]

  // Fixed targets and enables, registered so outputs come from flops
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      buck3_output_code_o <= pmic_pkg::CODE_1V8;
      buck2_output_code_o <= pmic_pkg::CODE_1V8;
      buck3_en_o <= 1'b0;
      buck2_en_o <= 1'b0;
      core_buck_en_o <= 1'b0;
    end else begin
      buck3_output_code_o <= buck3_dflt; // [R1]
      buck2_output_code_o <= buck2_dflt; // [R2]
      buck3_en_o <= en3_s; // [R4]
      buck2_en_o <= en2_s; // [R4]
      core_buck_en_o <= en1_s; // [R4]
    end
  end

  // Debounce: the new level must hold for the whole filter time
  wire warm_raw = ~warm_n_s;
  wire deb_done = deb_cnt_q == DW'(DEB_CYC - 1);
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      warm_deb_q <= 1'b0;
      deb_cnt_q <= '0;
    end else if (warm_raw == warm_deb_q) begin
      deb_cnt_q <= '0; // [R6]
    end else if (deb_done) begin
      warm_deb_q <= warm_raw; // [R7]
      deb_cnt_q <= '0;
    end else begin
      deb_cnt_q <= deb_cnt_q + DW'(1);
    end
  end

  // Reset generator. Power-up reset starts the hold, a low rail or an
  // active warm reset restarts it, and the delay runs only after both
  // have gone away.
  wire hold_cause = ~rail_s | warm_deb_q; // [R8] [R10]
  wire hold_done = hold_cnt_q == HW'(HOLD_CYC - 1);
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_hold_q <= 1'b1; // [R8]
      hold_cnt_q <= '0;
    end else if (hold_cause) begin
      rst_hold_q <= 1'b1;
      hold_cnt_q <= '0;
    end else if (rst_hold_q) begin
      if (hold_done) begin
        rst_hold_q <= 1'b0; // [R9]
      end
      hold_cnt_q <= hold_cnt_q + HW'(1);
    end
  end

  // Open-drain reset: enable pulls the line low
  assign system_reset_out_oe_o = rst_hold_q; // [R8]
  assign system_reset_out_o = 1'b0;

  // Bus condition detection on synchronised lines
  wire scl_rise = scl_s & ~scl_p_q; // [R11]
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s; // [R15]
  wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s; // [R15]
  wire byte_in = scl_fall & (cnt_q == 4'h8);
  wire addr_hit = sr_q[7:1] == pmic_pkg::DEV_ADDR; // [R13]
  wire wr_fire = (st_q == pmic_pkg::SS_WDAT) & byte_in; // [R21]

  // Register read decode; anything not mapped reads all ones
  function automatic logic [7:0] rd_byte(logic [7:0] p, c, logic [3:0] s);
    logic [7:0] v;
    v = pmic_pkg::RD_UNMAPPED; // [R14]
    if (p == pmic_pkg::REG_REVISION) begin
      v = pmic_pkg::REVISION_VAL; // [R20]
    end else if (p == pmic_pkg::REG_CORE_TGT) begin
      v = c;
    end else if (p == pmic_pkg::REG_STATUS) begin
      v = 8'h00;
      v[pmic_pkg::ST_CORE_EN] = s[0];
      v[pmic_pkg::ST_BUCK2_EN] = s[1];
      v[pmic_pkg::ST_BUCK3_EN] = s[2];
      v[pmic_pkg::ST_RST_HOLD] = s[3];
    end
    return v;
  endfunction

  // Every source is an argument, so a changed register shows at once
  wire [7:0] rd_val = rd_byte(ptr_q, core_q,
    {rst_hold_q, buck3_en_o, buck2_en_o, core_buck_en_o});

  // Core target: default while reset holds, else software may write.
  // Only a system reset reloads it; the bus state and other targets
  // are left alone.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_q <= pmic_pkg::CODE_1V2;
    end else if (rst_hold_q) begin
      core_q <= core_dflt; // [R5] [R3]
    end else if (wr_fire && ptr_q == pmic_pkg::REG_CORE_TGT) begin
      core_q <= sr_q; // [R12]
    end
  end
  assign core_buck_output_code_o = core_q;

  // Previous levels; reset matches the synchroniser, so no false start or stop
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Serial slave. Data moves only on a falling clock, sampled on a
  // rising one; start and stop take priority over everything else.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= pmic_pkg::SS_IDLE;
      nxt_q <= pmic_pkg::SS_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      ptr_q <= 8'h00;
      sda_oe_q <= 1'b0;
    end else if (start_c) begin
      st_q <= pmic_pkg::SS_ADDR; // [R16]
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= pmic_pkg::SS_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        pmic_pkg::SS_ADDR, pmic_pkg::SS_PTR, pmic_pkg::SS_WDAT: begin
          if (scl_rise && cnt_q < 4'h8) begin
            sr_q <= {sr_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_in) begin
            st_q <= pmic_pkg::SS_HAND;
            sda_oe_q <= 1'b1; // [R17]
            if (st_q == pmic_pkg::SS_ADDR) begin
              if (!addr_hit) begin
                st_q <= pmic_pkg::SS_IDLE; // [R13]
                sda_oe_q <= 1'b0;
              end
              nxt_q <= sr_q[0] ? pmic_pkg::SS_TX : pmic_pkg::SS_PTR;
            end else if (st_q == pmic_pkg::SS_PTR) begin
              ptr_q <= sr_q; // [R21]
              nxt_q <= pmic_pkg::SS_WDAT;
            end else begin
              nxt_q <= pmic_pkg::SS_WDAT;
            end
          end
        end
        pmic_pkg::SS_HAND: begin
          // Ninth clock ends here; hand the line over
          if (scl_fall) begin // [R18]
            cnt_q <= 4'h0;
            st_q <= nxt_q;
            sda_oe_q <= 1'b0;
            if (nxt_q == pmic_pkg::SS_TX) begin
              sr_q <= rd_val;
              sda_oe_q <= ~rd_val[7];
            end
          end
        end
        pmic_pkg::SS_TX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              st_q <= pmic_pkg::SS_MACK;
              sda_oe_q <= 1'b0;
            end else begin
              sr_q <= {sr_q[6:0], 1'b0};
              sda_oe_q <= ~sr_q[6]; // [R15]
            end
          end
        end
        pmic_pkg::SS_MACK: begin
          // Master ack sends the same register again; nack ends it
          if (scl_rise) begin
            if (sda_s) begin
              st_q <= pmic_pkg::SS_IDLE; // [R19]
            end else begin
              st_q <= pmic_pkg::SS_HAND;
              nxt_q <= pmic_pkg::SS_TX;
            end
          end
        end
        default: begin
          st_q <= pmic_pkg::SS_IDLE;
        end
      endcase
    end
  end

  // The device only ever pulls the data line low
  assign bus.dev_sda_oe = sda_oe_q;
  assign bus.dev_sda_o = 1'b0;
endmodule // pmic_dev

// ### pmic_pkg.sv
/*
  Shared constants and types for the power-management control block:
  clock rate, timing counts, bus address, register offsets and the
  host-side register map.
  Assumes a 20 MHz system clock on both ends.
*/
package pmic_pkg;

  // Clock and serial bus rates
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SCL_HZ = 100_000;
  localparam int unsigned QTR_CYC = CLK_HZ / (4 * SCL_HZ);

  // Warm-reset debounce time, 30 ms
  localparam int unsigned DEB_MS = 30;
  localparam int unsigned DEB_CYC = CLK_HZ / 1000 * DEB_MS;

  // Reset hold: 100 ms per nF of delay capacitor, 1 nF fitted
  localparam int unsigned HOLD_MS_PER_NF = 100;
  localparam int unsigned CAP_NF = 1;
  localparam int unsigned HOLD_MS = HOLD_MS_PER_NF * CAP_NF;
  localparam int unsigned HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;

  // Voltage targets in millivolts and as 25 mV codes
  localparam int unsigned VSTEP_MV = 25;
  localparam int unsigned V1V2_MV = 1200;
  localparam int unsigned V1V6_MV = 1600;
  localparam int unsigned V1V8_MV = 1800;
  localparam int unsigned V3V3_MV = 3300;
  localparam logic [7:0] CODE_1V2 = 8'(V1V2_MV / VSTEP_MV);
  localparam logic [7:0] CODE_1V6 = 8'(V1V6_MV / VSTEP_MV);
  localparam logic [7:0] CODE_1V8 = 8'(V1V8_MV / VSTEP_MV);
  localparam logic [7:0] CODE_3V3 = 8'(V3V3_MV / VSTEP_MV);

  // Serial slave address and device register map
  localparam logic [6:0] DEV_ADDR = 7'h48;
  localparam logic [7:0] REG_REVISION = 8'h00;
  localparam logic [7:0] REG_CORE_TGT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h11;
  localparam logic [7:0] REVISION_VAL = 8'h5A; // Arbitrary value
  localparam logic [7:0] RD_UNMAPPED = 8'hFF;

  // Device status register fields
  localparam int unsigned ST_CORE_EN = 0;
  localparam int unsigned ST_BUCK2_EN = 1;
  localparam int unsigned ST_BUCK3_EN = 2;
  localparam int unsigned ST_RST_HOLD = 3;

  // Host Wishbone register map
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_PTR = 8'h04;
  localparam logic [7:0] WB_WDAT = 8'h08;
  localparam logic [7:0] WB_STAT = 8'h0C;
  localparam int unsigned CMD_GO = 0;
  localparam int unsigned CMD_RD = 1;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_NACK = 1;
  localparam int unsigned STAT_RDAT = 8;

  typedef enum logic [2:0] {
    SS_IDLE, SS_ADDR, SS_PTR, SS_WDAT, SS_HAND, SS_TX, SS_MACK
  } pmic_sst_t;

  typedef enum logic [1:0] {
    HS_IDLE, HS_START, HS_BIT, HS_STOP
  } pmic_hst_t;

endpackage

// ### pmic_i2c_if.sv
/*
  Two-wire serial bus between the host controller and the device.
  Both lines are open drain with a pull-up: a line is low while any
  party enables its driver. Only the host drives the clock line.
*/
`timescale 1ns/100ps
interface pmic_i2c_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND resolution with pull-up
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe | dev_sda_oe) ? 1'b0 : 1'b1;

  modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
    output host_sda_oe, input scl, input sda);
  modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface // pmic_i2c_if

// ### pmic_sync.sv
/*
  Two-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level; buses of related bits must not
  pass through here.
*/
`timescale 1ns/100ps
module pmic_sync #(
  parameter int unsigned W = 1
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // pmic_sync

// ### pmic_host.sv
/*
  Host end: a serial bus master that software orders through four
  Wishbone classic registers. Writes one register, or reads one by
  setting the pointer and reading after a repeated start.
  Assumes the device never stretches the clock.
*/
`timescale 1ns/100ps
module pmic_host #(
  parameter int unsigned QTR_CYC = pmic_pkg::QTR_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  pmic_i2c_if.host bus
);
  localparam int unsigned QW = $clog2(QTR_CYC + 1);

  logic sda_s;
  pmic_pkg::pmic_hst_t st_q;
  logic [QW-1:0] qcnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [1:0] bi_q;
  logic [7:0] sh_q, ptr_q, wdat_q, rdat_q;
  logic rd_q, nack_q, scl_oe_q, sda_oe_q;

  // Only the data line comes back; clock is ours
  pmic_sync #(.W(1)) u_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .d_i(bus.sda),
    .q_o(sda_s)
  );

  wire busy = st_q != pmic_pkg::HS_IDLE;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_lo = req & wb_we_i & wb_sel_i[0];
  wire go = wr_lo & (wb_adr_i == pmic_pkg::WB_CMD) & ~busy
    & wb_dat_i[pmic_pkg::CMD_GO];
  wire tick = qcnt_q == QW'(QTR_CYC - 1);
  wire is_tx = ~(rd_q & bi_q == 2'd3);
  wire [31:0] stat = {16'h0000, rdat_q, 6'h00, nack_q, busy};

  // Byte sent in each slot of the transfer
  function automatic logic [7:0] tx_byte(input logic [1:0] b);
    logic [7:0] v;
    v = {pmic_pkg::DEV_ADDR, 1'b0};
    if (b == 2'd1) begin
      v = ptr_q;
    end else if (b == 2'd2) begin
      v = rd_q ? {pmic_pkg::DEV_ADDR, 1'b1} : wdat_q;
    end
    return v;
  endfunction

  // Wishbone slave: answer one cycle after the request, then drop
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ptr_q <= 8'h00;
      wdat_q <= 8'h00;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (wb_adr_i == pmic_pkg::WB_STAT) ? stat :
        (wb_adr_i == pmic_pkg::WB_PTR) ? {24'h0, ptr_q} :
        (wb_adr_i == pmic_pkg::WB_WDAT) ? {24'h0, wdat_q} : 32'h0;
      if (wr_lo && wb_adr_i == pmic_pkg::WB_PTR && !busy) begin
        ptr_q <= wb_dat_i[7:0];
      end
      if (wr_lo && wb_adr_i == pmic_pkg::WB_WDAT && !busy) begin
        wdat_q <= wb_dat_i[7:0];
      end
    end
  end

  // Bus master: four quarter-phases per bit, lines change on ticks
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= pmic_pkg::HS_IDLE;
      qcnt_q <= '0;
      ph_q <= 2'd0;
      bit_q <= 4'h0;
      bi_q <= 2'd0;
      sh_q <= 8'h00;
      rdat_q <= 8'h00;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (go) begin
      st_q <= pmic_pkg::HS_START; // [R16]
      rd_q <= wb_dat_i[pmic_pkg::CMD_RD];
      nack_q <= 1'b0;
      bi_q <= 2'd0;
      qcnt_q <= '0;
      ph_q <= 2'd0;
    end else if (busy) begin
      qcnt_q <= tick ? '0 : qcnt_q + QW'(1);
      if (tick) begin
        ph_q <= ph_q + 2'd1;
        case (st_q)
          pmic_pkg::HS_START: begin
            // Also serves as repeated start from a low clock
            if (ph_q == 2'd0) sda_oe_q <= 1'b0;
            if (ph_q == 2'd1) scl_oe_q <= 1'b0;
            if (ph_q == 2'd2) sda_oe_q <= 1'b1; // [R15]
            if (ph_q == 2'd3) begin
              scl_oe_q <= 1'b1;
              st_q <= pmic_pkg::HS_BIT;
              bit_q <= 4'h0;
              sh_q <= tx_byte(bi_q);
            end
          end
          pmic_pkg::HS_BIT: begin
            if (ph_q == 2'd0) begin
              // Released for slave ack, read bits and final nack
              sda_oe_q <= (bit_q < 4'h8) & is_tx & ~sh_q[7]; // [R19]
            end
            if (ph_q == 2'd1) scl_oe_q <= 1'b0;
            if (ph_q == 2'd2) begin
              if (bit_q < 4'h8) begin
                sh_q <= {sh_q[6:0], sda_s};
              end else if (is_tx && sda_s) begin
                nack_q <= 1'b1;
              end
            end
            if (ph_q == 2'd3) begin
              scl_oe_q <= 1'b1;
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) begin // [R18]
                bit_q <= 4'h0;
                bi_q <= bi_q + 2'd1;
                sh_q <= tx_byte(bi_q + 2'd1);
                if (nack_q || bi_q == 2'd3 || (!rd_q && bi_q == 2'd2)) begin
                  st_q <= pmic_pkg::HS_STOP;
                end else if (rd_q && bi_q == 2'd1) begin
                  st_q <= pmic_pkg::HS_START; // [R21]
                end
                if (bi_q == 2'd3) rdat_q <= sh_q;
              end
            end
          end
          pmic_pkg::HS_STOP: begin
            if (ph_q == 2'd0) sda_oe_q <= 1'b1;
            if (ph_q == 2'd1) scl_oe_q <= 1'b0;
            if (ph_q == 2'd2) sda_oe_q <= 1'b0; // [R16]
            if (ph_q == 2'd3) st_q <= pmic_pkg::HS_IDLE;
          end
          default: st_q <= pmic_pkg::HS_IDLE;
        endcase
      end
    end
  end

  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_oe = sda_oe_q;
  assign bus.host_sda_o = 1'b0;
endmodule // pmic_host

// ### pmic_bus_monitor.sv
/*
  Concurrent checks on the two-wire link between the two ends.
  Assumes the wires come in as plain inputs, slow against the clock.
*/
`timescale 1ns/100ps
module pmic_bus_monitor (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, frame_q, adr_ok_q, rd_q, nack_q;
  logic [3:0] bit_q, nbyte_q;
  logic [7:0] sh_q;
  // Line events, one clock late; framing restarts the bit count
  wire start_w = scl && scl_q && sda_q && !sda;
  wire stop_w = scl && scl_q && !sda_q && sda;
  wire rise_w = scl && !scl_q;
  wire ack_rise_w = rise_w && bit_q == 4'h8;
  wire [3:0] bit_d = (start_w || stop_w) ? 4'h0 : !rise_w ? bit_q :
    (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
  // Frame tracker in one block, traded for size
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {scl_q, sda_q, frame_q, adr_ok_q, rd_q, nack_q} <= 6'h30;
      {bit_q, nbyte_q, sh_q} <= 16'h0000;
    end else begin
      {scl_q, sda_q, bit_q} <= {scl, sda, bit_d};
      if (rise_w) sh_q <= {sh_q[6:0], sda};
      if (start_w || stop_w) frame_q <= start_w;
      if (start_w) {nbyte_q, adr_ok_q, rd_q, nack_q} <= 7'h00;
      if (ack_rise_w) nbyte_q <= nbyte_q + 4'h1;
      if (ack_rise_w && nbyte_q == 4'h0) begin
        adr_ok_q <= sh_q[7:1] == pmic_pkg::DEV_ADDR;
        rd_q <= sh_q[0];
      end
      if (ack_rise_w && rd_q && sda) nack_q <= 1'b1;
    end
  end
  default clocking mon_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // Wire rules of both ends
  dev_data_steady_a: assert property (
    scl && scl_q |-> $stable(dev_sda_oe))
    else $error("device data moved, clock high");
  host_framing_only_a: assert property (
    scl && scl_q && $changed(host_sda_oe) |-> start_w || stop_w)
    else $error("host data moved, clock high");
  clock_in_frame_a: assert property (rise_w |-> frame_q)
    else $error("clock outside frame");
  nine_clocks_a: assert property (
    start_w || stop_w |-> bit_q == (frame_q ? 4'h1 : 4'h0))
    else $error("byte not nine clocks");
  addr_ack_a: assert property (
    ack_rise_w && nbyte_q == 4'h0 && sh_q[7:1] == pmic_pkg::DEV_ADDR
    |-> dev_sda_oe [*3])
    else $error("address not acked");
  byte_ack_a: assert property (
    ack_rise_w && nbyte_q != 4'h0 && adr_ok_q && !rd_q |-> dev_sda_oe)
    else $error("byte not acked");
  nack_release_a: assert property (nack_q && scl |-> !dev_sda_oe)
    else $error("data held after nack");
  drive_window_a: assert property (
    dev_sda_oe |-> bit_q >= 4'h8 || rd_q)
    else $error("device drove out of turn");
  cover property (ack_rise_w && rd_q && sda);
  cover property (start_w && frame_q);
  cover property (ack_rise_w && nbyte_q == 4'h2 && !rd_q);
endmodule // pmic_bus_monitor

// ### pmic_control_pins_and_i2c_slave_tb.sv
/*
  Bench joining host and device ends: Wishbone orders, device pins,
  reset output and register contents.
  Assumes shortened hold, debounce and bus quarter counts.
*/
`timescale 1ns/100ps
module pmic_control_pins_and_i2c_slave_tb;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00, rb, core_code, b2_code, b3_code;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_rdat, q;
  logic [2:0] sel = 3'h0, en = 3'h0, en_o;
  logic warm_n = 1'b1, rail = 1'b0, rst_o, rst_oe, nk;
  int mismatches = 0, samples_checked = 0;
  pmic_i2c_if bus_if ();
  // Both ends and the link checker
  pmic_dev #(.HOLD_CYC(40), .DEB_CYC(20)) pmic_dev_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .buck3_default_select_i(sel[2]), .buck2_default_select_i(sel[1]),
    .core_buck_default_select_i(sel[0]), .buck3_enable_in_i(en[2]),
    .buck2_enable_in_i(en[1]), .core_buck_enable_in_i(en[0]),
    .warm_reset_in_n_i(warm_n), .backup_rail_ok_i(rail), .bus(bus_if.dev),
    .core_buck_output_code_o(core_code), .buck2_output_code_o(b2_code),
    .buck3_output_code_o(b3_code), .core_buck_en_o(en_o[0]),
    .buck2_en_o(en_o[1]), .buck3_en_o(en_o[2]),
    .system_reset_out_o(rst_o), .system_reset_out_oe_o(rst_oe));
  pmic_host #(.QTR_CYC(13)) pmic_host_i (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .bus(bus_if.host));
  pmic_bus_monitor pmic_bus_monitor_i (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
  always #25 sys_clk_i = ~sys_clk_i;
  // Compare and tally
  task automatic check(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // Classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk_i);
    {wb_cyc, wb_stb, wb_we, wb_sel} <= {2'h3, we, 4'hF};
    {wb_adr, wb_dat} <= {a, d};
    while (wb_ack !== 1'b1) @(posedge sys_clk_i);
    r = wb_rdat;
    {wb_cyc, wb_stb} <= 2'h0;
  endtask
  // Serial transfer ordered through the host, then polled to the end
  task automatic dev_op(input logic rd, input logic [7:0] ptr, wd);
    int n;
    wb(1'b1, pmic_pkg::WB_PTR, {24'h0, ptr}, q);
    wb(1'b1, pmic_pkg::WB_WDAT, {24'h0, wd}, q);
    wb(1'b1, pmic_pkg::WB_CMD, {30'h0, rd, 1'b1}, q);
    q = 32'h1;
    for (n = 0; n < 3000 && q[pmic_pkg::STAT_BUSY] !== 1'b0; n++)
      wb(1'b0, pmic_pkg::WB_STAT, 32'h0, q);
    {rb, nk} = {q[15:8], q[pmic_pkg::STAT_NACK]};
    if (n == 3000) mismatches++;
  endtask
  task automatic reg_chk(input string nm, input logic [7:0] ptr, exp);
    dev_op(1'b1, ptr, 8'h00);
    check(nm, rb, exp);
    check("nack", {7'h0, nk}, 8'h00);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Power-up with the backup rail low, then pins, bus and warm reset
  initial begin
    cyc(12);
    nrst_i <= 1'b1;
    cyc(20);
    check("rst oe", {7'h0, rst_oe}, 8'h01);
    check("rst level", {7'h0, rst_o}, 8'h00);
    rail <= 1'b1;
    cyc(36);
    check("hold early", {7'h0, rst_oe}, 8'h01);
    cyc(12);
    check("hold over", {7'h0, rst_oe}, 8'h00);
    check("core lo", core_code, pmic_pkg::CODE_1V2);
    check("buck2 lo", b2_code, pmic_pkg::CODE_1V8);
    check("buck3 lo", b3_code, pmic_pkg::CODE_1V8);
    sel <= 3'h7;
    nrst_i <= 1'b0;
    cyc(12);
    nrst_i <= 1'b1;
    cyc(60);
    check("core hi", core_code, pmic_pkg::CODE_1V6);
    check("buck2 hi", b2_code, pmic_pkg::CODE_3V3);
    check("buck3 hi", b3_code, pmic_pkg::CODE_3V3);
    for (int i = 0; i < 8; i++) begin
      en <= 3'(i);
      cyc(4);
      check("enables", {5'h0, en_o}, 8'(i));
    end
    en <= 3'h5;
    wb(1'b0, 8'h20, 32'h0, q);
    check("wb unmapped", q[7:0], 8'h00);
    reg_chk("status", pmic_pkg::REG_STATUS, 8'h05);
    reg_chk("rev", pmic_pkg::REG_REVISION, pmic_pkg::REVISION_VAL);
    reg_chk("unmapped", 8'h37, pmic_pkg::RD_UNMAPPED);
    dev_op(1'b0, pmic_pkg::REG_REVISION, 8'h12);
    reg_chk("rev ro", pmic_pkg::REG_REVISION, pmic_pkg::REVISION_VAL);
    dev_op(1'b0, pmic_pkg::REG_CORE_TGT, 8'h30);
    check("core wr", core_code, 8'h30);
    reg_chk("core rd", pmic_pkg::REG_CORE_TGT, 8'h30);
    warm_n <= 1'b0;
    cyc(10);
    warm_n <= 1'b1;
    cyc(40);
    check("glitch", {7'h0, rst_oe}, 8'h00);
    check("glitch core", core_code, 8'h30);
    warm_n <= 1'b0;
    cyc(14);
    check("debounce", {7'h0, rst_oe}, 8'h00);
    cyc(16);
    check("warm pulse", {7'h0, rst_oe}, 8'h01);
    check("core back", core_code, pmic_pkg::CODE_1V6);
    check("buck2 kept", b2_code, pmic_pkg::CODE_3V3);
    warm_n <= 1'b1;
    cyc(100);
    check("warm end", {7'h0, rst_oe}, 8'h00);
    complete_run();
  end
  // Watchdog, far beyond the expected run length
  initial begin
    cyc(60000);
    mismatches++;
    complete_run();
  end
endmodule // pmic_control_pins_and_i2c_slave_tb
